// *** bat_cmd_regs.vh ***
// Constants for the battery threshold command block: command codes,
// reset values, mode word bit positions and SMBus byte phases.
// Assumes inclusion by bare name from the design files.
`ifndef BAT_CMD_REGS_VH
`define BAT_CMD_REGS_VH

// Command codes
`define BAT_CMD_VENDOR        8'h00
`define BAT_CMD_LOW_CAP       8'h01
`define BAT_CMD_LOW_TIME      8'h02

// Reset values
`define BAT_VENDOR_RST        16'h0000
`define BAT_LOW_TIME_RST      16'h000a
`define BAT_LOW_CAP_PCT       10

// Mode word bit positions
`define BAT_MODE_SUPPRESS_BIT 13
`define BAT_MODE_UNIT_BIT     15

// Byte phases inside one SMBus transaction
`define BAT_PH_ADDR           3'h0
`define BAT_PH_CMD            3'h1
`define BAT_PH_LO             3'h2
`define BAT_PH_HI             3'h3

// Bit counter end value and zero threshold
`define BAT_LAST_BIT          3'h7
`define BAT_THR_OFF           16'h0000

// Clock rate and time base
`define BAT_CLK_HZ            50000000
`define BAT_MS_PER_S          1000

`endif

// *** bat_alarm_eval.v ***
// Threshold comparison and warning broadcast gating.
// Assumes measurement strobes and the mode word come from logic on i_mclk.
`timescale 1ns/10ps
`include "bat_cmd_regs.vh"

module bat_alarm_eval #(
  parameter SUPP_CYC = 50000000              // Withhold period in cycles
) (
  input  wire        i_mclk,
  input  wire        i_rst_n,
  input  wire [15:0] i_cap_meas,             // Charge left measurement
  input  wire        i_cap_upd,              // New charge value strobe
  input  wire [15:0] i_time_est,             // Mean runtime estimate
  input  wire        i_time_upd,             // New runtime value strobe
  input  wire [15:0] i_cap_thr,              // Low capacity threshold
  input  wire [15:0] i_time_thr,             // Low time threshold
  input  wire        i_thr_wr,               // Host wrote a threshold
  input  wire        i_suppress,             // Broadcast suppress mode bit
  output wire        o_cap_alarm,            // Capacity alarm flag
  output wire        o_time_alarm,           // Time alarm flag
  output wire        o_warn                  // One warning message strobe
);

  reg        cap_alarm_ff;                   // Capacity comparison result
  reg        time_alarm_ff;                  // Time comparison result
  reg        eval_ff;                        // Evaluation done last cycle
  reg        warn_ff;                        // Warning strobe
  reg        supp_prev_ff;                   // Suppress bit, one cycle late
  reg [31:0] supp_cnt_ff;                    // Withhold countdown

  wire eval_cap  = i_cap_upd | i_thr_wr;
  wire eval_time = i_time_upd | i_thr_wr;
  wire withhold  = (supp_cnt_ff != 32'h0000_0000);

  // Zero threshold disables, else strictly below raises
  function below;
    input [15:0] val;
    input [15:0] thr;
    begin
      below = (thr != `BAT_THR_OFF) && (val < thr);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Comparisons, redone on every value update and threshold write
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cap_alarm_ff  <= 1'b0;
      time_alarm_ff <= 1'b0;
      eval_ff       <= 1'b0;
    end
    else
    begin
      if (eval_cap)
        cap_alarm_ff <= below(i_cap_meas, i_cap_thr);   // RULE_05 RULE_06 RULE_16
      if (eval_time)
        time_alarm_ff <= below(i_time_est, i_time_thr); // RULE_11 RULE_12 RULE_16
      eval_ff <= eval_cap | eval_time;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Withhold timer: starts when suppress bit rises, runs a fixed period.
  // The mode word is owned elsewhere, so the bit is not cleared here.
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      supp_prev_ff <= 1'b0;
      supp_cnt_ff  <= 32'h0000_0000;
      warn_ff      <= 1'b0;
    end
    else
    begin
      supp_prev_ff <= i_suppress;
      if (i_suppress && !supp_prev_ff)
        supp_cnt_ff <= SUPP_CYC[31:0];                   // RULE_09 RULE_14
      else if (withhold)
        supp_cnt_ff <= supp_cnt_ff - 32'h0000_0001;
      // One message per evaluation while any alarm stands
      warn_ff <= eval_ff && (cap_alarm_ff || time_alarm_ff)
                 && !(withhold && i_suppress);           // RULE_09
    end
  end

  assign o_cap_alarm  = cap_alarm_ff;
  assign o_time_alarm = time_alarm_ff;
  assign o_warn       = warn_ff;

endmodule // bat_alarm_eval

// *** bat_thresh_cmds.v ***
// SMBus word command slave for the vendor word and both alarm thresholds,
// with the alarm comparison unit beneath it.
// Assumes SCL/SDA arrive from pins (open drain, resolved outside) and the
// mode word and measurements come from logic on i_mclk.
//
// Contract
// RULE_01: Answer all defined command codes here
// RULE_02: Defaults, modes and functions all implemented
// RULE_03: Code 0x00 takes word read/write only
// RULE_04: Code 0x01 stores and returns capacity threshold
// RULE_05: Capacity below threshold sends warning, flag set
// RULE_06: Zero capacity threshold disables that alarm
// RULE_07: Capacity threshold defaults to ten percent rated
// RULE_08: Units mAh or 10mWh per unit bit
// RULE_09: Suppress bit withholds warnings for set period
// RULE_10: Code 0x02 stores and returns minutes threshold
// RULE_11: Runtime below threshold sends warning, flag set
// RULE_12: Zero time threshold disables that alarm
// RULE_13: Time threshold defaults to ten minutes
// RULE_14: Suppress bit is mode bit 13
// RULE_15: Unit bit is mode bit 15
// RULE_16: Recompare on value update or threshold write
`timescale 1ns/10ps
`include "bat_cmd_regs.vh"

module bat_thresh_cmds #(
  parameter [6:0]  DEV_ADDR     = 7'h2a,     // Slave address, arbitrary
  parameter [15:0] RATED_CHARGE = 16'h1000,  // Rated charge value
  parameter        SUPPRESS_MS  = 1000       // Withhold period in ms
) (
  input  wire        i_mclk,
  input  wire        i_rst_n,
  input  wire        i_scl,                  // SMBus clock pin level
  input  wire        i_sda,                  // SMBus data pin level
  output wire        o_sda,                  // Data drive value, always low
  output wire        o_sda_oe,               // High while pulling SDA low
  input  wire [15:0] i_config_word,          // Mode word from mode register
  input  wire [15:0] i_charge_left_measure,  // Remaining charge value
  input  wire        i_charge_left_upd,      // Strobe: new charge value
  input  wire [15:0] i_mean_runtime_estimate,// Remaining minutes estimate
  input  wire        i_mean_runtime_upd,     // Strobe: new runtime value
  output wire [15:0] o_vendor_access_word,   // Vendor word contents
  output wire [15:0] o_low_capacity_threshold,
  output wire [15:0] o_low_time_threshold,
  output wire        o_cap_unit_10mwh,       // Threshold unit is 10mWh
  output wire        o_cap_alarm,            // Remaining capacity alarm flag
  output wire        o_time_alarm,           // Remaining time alarm flag
  output wire        o_warning_broadcast_msg // Strobe: send warning message
);

  // Derived counts
  localparam [31:0] LOW_CAP_W   = (RATED_CHARGE * `BAT_LOW_CAP_PCT) / 100;
  localparam        SUPP_CYC    = SUPPRESS_MS * (`BAT_CLK_HZ / `BAT_MS_PER_S);

  // Slave states
  localparam [2:0] ST_IDLE = 3'h0;           // Not addressed
  localparam [2:0] ST_RX   = 3'h1;           // Shifting a byte in
  localparam [2:0] ST_ACK  = 3'h2;           // Driving our acknowledge
  localparam [2:0] ST_TX   = 3'h3;           // Shifting a byte out
  localparam [2:0] ST_TACK = 3'h4;           // Reading master acknowledge

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  reg [1:0] scl_sync_ff;                     // Two stage SCL sync
  reg [1:0] sda_sync_ff;                     // Two stage SDA sync
  reg       scl_prev_ff;                     // Synced SCL, one cycle late
  reg       sda_prev_ff;                     // Synced SDA, one cycle late

  wire scl_s    = scl_sync_ff[1];
  wire sda_s    = sda_sync_ff[1];
  wire scl_rise = scl_s & ~scl_prev_ff;
  wire scl_fall = ~scl_s & scl_prev_ff;
  wire bus_start = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  wire bus_stop  = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

  // Only the second stage feeds any logic
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      scl_sync_ff <= 2'b11;
      sda_sync_ff <= 2'b11;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[0], i_scl};
      sda_sync_ff <= {sda_sync_ff[0], i_sda};
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command helpers
  function mapped;
    input [7:0] c;
    begin
      mapped = (c == `BAT_CMD_VENDOR) || (c == `BAT_CMD_LOW_CAP) ||
               (c == `BAT_CMD_LOW_TIME);                 // RULE_01
    end
  endfunction

  reg [15:0] vendor_ff;                      // Vendor access word
  reg [15:0] low_cap_ff;                     // Low capacity threshold
  reg [15:0] low_time_ff;                    // Low time threshold

  function [15:0] reg_val;
    input [7:0] c;
    begin
      case (c)
        `BAT_CMD_LOW_CAP:  reg_val = low_cap_ff;         // RULE_04
        `BAT_CMD_LOW_TIME: reg_val = low_time_ff;        // RULE_10
        default:           reg_val = vendor_ff;          // RULE_03
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Transaction engine
  reg [2:0]  state_ff;                       // Slave state
  reg [2:0]  bit_cnt_ff;                     // Bit within byte
  reg [7:0]  shift_ff;                       // Receive shifter
  reg [2:0]  phase_ff;                       // Byte phase in transaction
  reg        got_ff;                         // Full byte or master ack seen
  reg        read_ff;                        // Current address asked read
  reg [7:0]  cmd_ff;                         // Latched command code
  reg        cmd_ok_ff;                      // Command valid this frame
  reg [7:0]  lo_ff;                          // Low data byte of a write
  reg [7:0]  tx_ff;                          // Transmit shifter
  reg [7:0]  rd_hi_ff;                       // High byte awaiting send
  reg        tx_hi_ff;                       // High byte already sent
  reg        sda_oe_ff;                      // Pull SDA low
  reg        thr_wr_ff;                      // Strobe: threshold written

  wire [15:0] rd_word = reg_val(cmd_ff);

  // Byte level sequencing; stops and starts override every state.
  // No clock stretching: the host's SCL alone paces the transfer.
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_ff    <= ST_IDLE;
      bit_cnt_ff  <= 3'h0;
      shift_ff    <= 8'h00;
      phase_ff    <= `BAT_PH_ADDR;
      got_ff      <= 1'b0;
      read_ff     <= 1'b0;
      cmd_ff      <= 8'h00;
      cmd_ok_ff   <= 1'b0;
      lo_ff       <= 8'h00;
      tx_ff       <= 8'h00;
      rd_hi_ff    <= 8'h00;
      tx_hi_ff    <= 1'b0;
      sda_oe_ff   <= 1'b0;
      thr_wr_ff   <= 1'b0;
      vendor_ff   <= `BAT_VENDOR_RST;
      low_cap_ff  <= LOW_CAP_W[15:0];                    // RULE_07
      low_time_ff <= `BAT_LOW_TIME_RST;                  // RULE_13
    end
    else
    begin
      thr_wr_ff <= 1'b0;
      if (bus_start)
      begin
        // Start or repeated start: expect an address byte
        state_ff   <= ST_RX;
        bit_cnt_ff <= 3'h0;
        phase_ff   <= `BAT_PH_ADDR;
        got_ff     <= 1'b0;
        sda_oe_ff  <= 1'b0;
      end
      else if (bus_stop)
      begin
        // Half-finished writes are dropped, so byte writes never land
        state_ff  <= ST_IDLE;
        sda_oe_ff <= 1'b0;
        cmd_ok_ff <= 1'b0;
      end
      else
      begin
        case (state_ff)
          ST_RX:
            if (scl_rise)
            begin
              shift_ff   <= {shift_ff[6:0], sda_s};
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
              if (bit_cnt_ff == `BAT_LAST_BIT)
                got_ff <= 1'b1;
            end
            else if (scl_fall && got_ff)
            begin
              got_ff   <= 1'b0;
              phase_ff <= phase_ff + 3'h1;
              state_ff <= ST_ACK;
              sda_oe_ff <= 1'b1;
              case (phase_ff)
                `BAT_PH_ADDR:
                  // Read only after a command in this frame
                  if (shift_ff[7:1] == DEV_ADDR && (!shift_ff[0] || cmd_ok_ff))
                  begin
                    read_ff  <= shift_ff[0];
                    tx_ff    <= rd_word[7:0];            // RULE_04 RULE_10
                    rd_hi_ff <= rd_word[15:8];
                    tx_hi_ff <= 1'b0;
                  end
                  else
                  begin
                    state_ff  <= ST_IDLE;
                    sda_oe_ff <= 1'b0;
                  end
                `BAT_PH_CMD:
                  if (mapped(shift_ff))                  // RULE_01
                  begin
                    cmd_ff    <= shift_ff;
                    cmd_ok_ff <= 1'b1;
                  end
                  else
                  begin
                    state_ff  <= ST_IDLE;
                    sda_oe_ff <= 1'b0;
                  end
                `BAT_PH_LO:
                  lo_ff <= shift_ff;
                `BAT_PH_HI:
                begin
                  // Commit only a whole word, low byte first
                  case (cmd_ff)
                    `BAT_CMD_LOW_CAP:
                    begin
                      low_cap_ff <= {shift_ff, lo_ff};   // RULE_04 RULE_07 RULE_08
                      thr_wr_ff  <= 1'b1;                // RULE_16
                    end
                    `BAT_CMD_LOW_TIME:
                    begin
                      low_time_ff <= {shift_ff, lo_ff};  // RULE_10 RULE_13
                      thr_wr_ff   <= 1'b1;               // RULE_16
                    end
                    default:
                      vendor_ff <= {shift_ff, lo_ff};    // RULE_03
                  endcase
                end
                default:
                begin
                  // Excess bytes are not acknowledged
                  state_ff  <= ST_IDLE;
                  sda_oe_ff <= 1'b0;
                end
              endcase
            end
          ST_ACK:
            if (scl_fall)
            begin
              bit_cnt_ff <= 3'h0;
              if (read_ff)
              begin
                state_ff  <= ST_TX;
                sda_oe_ff <= ~tx_ff[7];
              end
              else
              begin
                state_ff  <= ST_RX;
                sda_oe_ff <= 1'b0;
              end
            end
          ST_TX:
            if (scl_rise)
            begin
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
              if (bit_cnt_ff == `BAT_LAST_BIT)
                got_ff <= 1'b1;
            end
            else if (scl_fall)
            begin
              if (got_ff)
              begin
                got_ff    <= 1'b0;
                state_ff  <= ST_TACK;
                sda_oe_ff <= 1'b0;
              end
              else
              begin
                tx_ff     <= {tx_ff[6:0], 1'b0};
                sda_oe_ff <= ~tx_ff[6];
              end
            end
          ST_TACK:
            if (scl_rise)
              got_ff <= ~sda_s;
            else if (scl_fall)
            begin
              got_ff     <= 1'b0;
              bit_cnt_ff <= 3'h0;
              // Master ack after low byte fetches the high byte
              if (got_ff && !tx_hi_ff)
              begin
                tx_ff     <= rd_hi_ff;
                tx_hi_ff  <= 1'b1;
                state_ff  <= ST_TX;
                sda_oe_ff <= ~rd_hi_ff[7];
              end
              else
                state_ff <= ST_IDLE;
            end
          default:
            sda_oe_ff <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unit bit is registered for a clean data output
  reg unit_ff;                               // Capacity unit selection

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      unit_ff <= 1'b0;
    else
      unit_ff <= i_config_word[`BAT_MODE_UNIT_BIT];      // RULE_08 RULE_15
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm comparisons and warning gating
  bat_alarm_eval #(
    .SUPP_CYC   (SUPP_CYC)
  ) u_alarm (
    .i_mclk     (i_mclk),
    .i_rst_n    (i_rst_n),
    .i_cap_meas (i_charge_left_measure),
    .i_cap_upd  (i_charge_left_upd),
    .i_time_est (i_mean_runtime_estimate),
    .i_time_upd (i_mean_runtime_upd),
    .i_cap_thr  (low_cap_ff),
    .i_time_thr (low_time_ff),
    .i_thr_wr   (thr_wr_ff),
    .i_suppress (i_config_word[`BAT_MODE_SUPPRESS_BIT]), // RULE_14
    .o_cap_alarm(o_cap_alarm),
    .o_time_alarm(o_time_alarm),
    .o_warn     (o_warning_broadcast_msg)
  );

  // Open drain: only ever pulls low
  assign o_sda                    = 1'b0;
  assign o_sda_oe                 = sda_oe_ff;
  assign o_vendor_access_word     = vendor_ff;
  assign o_low_capacity_threshold = low_cap_ff;
  assign o_low_time_threshold     = low_time_ff;
  assign o_cap_unit_10mwh         = unit_ff;

endmodule // bat_thresh_cmds

// *** bat_thresh_cmds_assertions.sv ***
// Concurrent checks on the threshold command block's ports.
// Assumes binding onto bat_thresh_cmds; one clock domain, i_mclk.
`timescale 1ns/10ps
module bat_thresh_cmds_assertions #(
  parameter        SUPPRESS_MS  = 1000
) (
  input wire        i_mclk,
  input wire        i_rst_n,
  input wire        i_scl,
  input wire        i_sda,
  input wire        o_sda,
  input wire        o_sda_oe,
  input wire [15:0] i_config_word,
  input wire [15:0] i_charge_left_measure,
  input wire        i_charge_left_upd,
  input wire [15:0] i_mean_runtime_estimate,
  input wire        i_mean_runtime_upd,
  input wire [15:0] o_vendor_access_word,
  input wire [15:0] o_low_capacity_threshold,
  input wire [15:0] o_low_time_threshold,
  input wire        o_cap_unit_10mwh,
  input wire        o_cap_alarm,
  input wire        o_time_alarm,
  input wire        o_warning_broadcast_msg
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  //////////////////////////////////////////////////////////////
  localparam int SUPP_CYC = SUPPRESS_MS * 50000;  // Withhold span in cycles
  logic [31:0] supp_cnt_ff;                       // Cycles since suppress rose
  // Counter restarts whenever the suppress bit is low
  always @(posedge i_mclk or negedge i_rst_n)
    supp_cnt_ff <= !i_rst_n ? 32'h0 : i_config_word[13] ? supp_cnt_ff + 32'h1 : 32'h0;
  // Zero threshold disables, else strictly below trips
  function automatic bit trips(logic [15:0] v, logic [15:0] t);
    return t != 16'h0000 && v < t;
  endfunction
  //////////////////////////////////////////////////////////////
  sequence cap_trip;
    i_charge_left_upd && !i_config_word[13]
      && trips(i_charge_left_measure, o_low_capacity_threshold);
  endsequence
  // Nothing that could start an evaluation for three cycles
  sequence quiet;
    (!i_charge_left_upd && !i_mean_runtime_upd && $stable(o_low_capacity_threshold)
      && $stable(o_low_time_threshold)) [*3];
  endsequence
  AST_CAP_FLAG: assert property (i_charge_left_upd |=> o_cap_alarm ==
    $past(trips(i_charge_left_measure, o_low_capacity_threshold)))
    else $error("capacity flag does not match comparison");
  AST_TIME_FLAG: assert property (i_mean_runtime_upd |=> o_time_alarm ==
    $past(trips(i_mean_runtime_estimate, o_low_time_threshold)))
    else $error("time flag does not match comparison");
  AST_FLAG_HOLD: assert property (quiet |=> $stable({o_cap_alarm, o_time_alarm}))
    else $error("alarm flag moved without an evaluation");
  AST_WARN_CAUSE: assert property (o_warning_broadcast_msg |->
    $past(o_cap_alarm || o_time_alarm))
    else $error("warning pulse without an alarm flag");
  AST_WARN_TRIP: assert property (!i_config_word[13] ##1 cap_trip
    ##1 !i_config_word[13] |=> o_warning_broadcast_msg)
    else $error("capacity trip gave no warning pulse");
  AST_CAP_ZERO: assert property ((o_low_capacity_threshold == 16'h0000) [*3]
    |-> !o_cap_alarm)
    else $error("capacity alarm with zero threshold");
  AST_TIME_ZERO: assert property ((o_low_time_threshold == 16'h0000) [*3]
    |-> !o_time_alarm)
    else $error("time alarm with zero threshold");
  AST_UNIT_BIT: assert property ($changed(i_config_word[15]) |=>
    o_cap_unit_10mwh == $past(i_config_word[15]))
    else $error("unit flag does not follow mode bit 15");
  AST_SUPPRESS: assert property (supp_cnt_ff > 32'd4 && supp_cnt_ff < SUPP_CYC - 8
    |-> !o_warning_broadcast_msg)
    else $error("warning pulse inside the withhold span");
  AST_SDA_LOW_SCL: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data pin moved while clock high");
endmodule // bat_thresh_cmds_assertions

bind bat_thresh_cmds bat_thresh_cmds_assertions #(.SUPPRESS_MS(SUPPRESS_MS))
  i_bat_thresh_cmds_assertions (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
  .o_sda_oe(o_sda_oe), .i_config_word(i_config_word),
  .i_charge_left_measure(i_charge_left_measure), .i_charge_left_upd(i_charge_left_upd),
  .i_mean_runtime_estimate(i_mean_runtime_estimate), .i_mean_runtime_upd(i_mean_runtime_upd),
  .o_vendor_access_word(o_vendor_access_word),
  .o_low_capacity_threshold(o_low_capacity_threshold),
  .o_low_time_threshold(o_low_time_threshold), .o_cap_unit_10mwh(o_cap_unit_10mwh),
  .o_cap_alarm(o_cap_alarm), .o_time_alarm(o_time_alarm),
  .o_warning_broadcast_msg(o_warning_broadcast_msg));

// *** bat_smbus_host.sv ***
// SMBus host model: word reads and writes toward the battery.
// Assumes the bench resolves SDA from both pull-down enables.
`timescale 1ns/10ps
module bat_smbus_host #(
  parameter [6:0] SLAVE_ADDR = 7'h2a  // Slave address, arbitrary
) (
  input  wire i_mclk,
  input  wire i_sda_line,             // Resolved SDA level
  output reg  o_scl = 1'b1,           // Clock, stands high between frames
  output reg  o_sda_oe = 1'b0         // High while host pulls SDA low
);
  // Quarter of a 160 ns clock period, moved on falling mclk
  task automatic qtr;
    repeat (2) @(negedge i_mclk);
  endtask
  // One bit: data set while low, sampled mid-high
  task automatic bit_slot(input logic tx, output logic rx);
    o_sda_oe = ~tx;
    qtr;
    o_scl = 1'b1;
    qtr;
    rx = i_sda_line;
    qtr;
    o_scl = 1'b0;
    qtr;
  endtask
  // Start or repeated start
  task automatic start_cond;
    o_sda_oe = 1'b0;
    qtr;
    o_scl = 1'b1;
    qtr;
    o_sda_oe = 1'b1;
    qtr;
    o_scl = 1'b0;
    qtr;
  endtask
  task automatic stop_cond;
    o_sda_oe = 1'b1;
    qtr;
    o_scl = 1'b1;
    qtr;
    o_sda_oe = 1'b0;
    qtr;
  endtask
  // Eight bits MSB first, then the ninth slot; last=1 leaves it released
  task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                         inout logic ok);
    logic b;
    for (int i = 7; i >= 0; i--)
      bit_slot(tx[i], rx[i]);
    bit_slot(last, b);
    ok = ok & ~b;
  endtask
  // Write word; full=0 cuts the frame after the low byte
  task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d, input logic full,
                         output logic ok);
    logic [7:0] r;
    ok = 1'b1;
    start_cond;
    byte_io({SLAVE_ADDR, 1'b0}, 1'b1, r, ok);
    byte_io(cmd, 1'b1, r, ok);
    byte_io(d[7:0], 1'b1, r, ok);
    if (full)
      byte_io(d[15:8], 1'b1, r, ok);
    stop_cond;
  endtask
  // Read word with repeated start; host acks low byte, refuses high
  task automatic rd_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
    logic [7:0] r;
    logic       a;
    ok = 1'b1;
    start_cond;
    byte_io({SLAVE_ADDR, 1'b0}, 1'b1, r, ok);
    byte_io(cmd, 1'b1, r, ok);
    start_cond;
    byte_io({SLAVE_ADDR, 1'b1}, 1'b1, r, ok);
    byte_io(8'hff, 1'b0, d[7:0], ok);
    byte_io(8'hff, 1'b1, d[15:8], a);
    stop_cond;
  endtask
endmodule // bat_smbus_host

// *** battery_alarm_threshold_cmds_tb.sv ***
// Self-checking bench for the battery threshold command block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/10ps
`define BAT_CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e); end end
module battery_alarm_threshold_cmds_tb;
  localparam int          SUPP_MS = 1;                         // Short withhold span
  localparam logic [15:0] CAP_DEF = 16'((32'h1000 * 10) / 100); // Ten percent rated
  logic        i_mclk = 1'b0;
  logic        rst_n  = 1'b0;
  logic        scl, host_oe, dut_oe, cap_upd = 1'b0, rt_upd = 1'b0;
  logic [15:0] cfg = 16'h0000, cap = 16'h0000, rt = 16'h0000;
  wire  [15:0] vend, lcap, ltime;
  wire         unit, cap_al, time_al, warn;
  wire         sda_line = ~(host_oe | dut_oe);  // Pulled up unless someone pulls
  int          failures = 0;
  int          checks = 0;
  always #10 i_mclk = ~i_mclk;
  //////////////////////////////////////////////////////////////
  bat_thresh_cmds #(.RATED_CHARGE(16'h1000), .SUPPRESS_MS(SUPP_MS)) i_bat_thresh_cmds (
    .i_mclk(i_mclk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_line), .o_sda(),
    .o_sda_oe(dut_oe), .i_config_word(cfg), .i_charge_left_measure(cap),
    .i_charge_left_upd(cap_upd), .i_mean_runtime_estimate(rt), .i_mean_runtime_upd(rt_upd),
    .o_vendor_access_word(vend), .o_low_capacity_threshold(lcap),
    .o_low_time_threshold(ltime), .o_cap_unit_10mwh(unit), .o_cap_alarm(cap_al),
    .o_time_alarm(time_al), .o_warning_broadcast_msg(warn));
  bat_smbus_host i_bat_smbus_host (.i_mclk(i_mclk), .i_sda_line(sda_line), .o_scl(scl),
    .o_sda_oe(host_oe));
  //////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic full,
                    input logic exp_ok);
    logic ok;
    i_bat_smbus_host.wr_word(c, d, full, ok);
    `BAT_CHK(ok, exp_ok)
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    i_bat_smbus_host.rd_word(c, d, ok);
    `BAT_CHK(ok, 1'b1)
    `BAT_CHK(d, e)
  endtask
  // One measurement strobe; flags stand a cycle later, the warning pulse a cycle after them
  task automatic meas(input logic tsel, input logic [15:0] v, input logic [1:0] ef,
                      input logic ew);
    if (tsel)
      {rt, rt_upd} = {v, 1'b1};
    else
      {cap, cap_upd} = {v, 1'b1};
    @(negedge i_mclk);
    {cap_upd, rt_upd} = 2'b00;
    @(negedge i_mclk);
    `BAT_CHK({cap_al, time_al}, ef)
    `BAT_CHK(warn, ew)
    repeat (3) @(negedge i_mclk);
  endtask
  //////////////////////////////////////////////////////////////
  // Watchdog: whole run is about 55k cycles
  initial
  begin
    #1600000;
    failures++;
    conclude;
  end
  // Main sequence
  initial
  begin
    repeat (6) @(negedge i_mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    `BAT_CHK(vend, 16'h0000)
    `BAT_CHK(lcap, CAP_DEF)
    `BAT_CHK(ltime, 16'h000a)
    rd(8'h00, 16'h0000);
    rd(8'h01, CAP_DEF);
    rd(8'h02, 16'h000a);
    wr(8'h00, 16'ha55a, 1'b1, 1'b1);
    rd(8'h00, 16'ha55a);
    wr(8'h01, 16'hffff, 1'b1, 1'b1);
    rd(8'h01, 16'hffff);
    wr(8'h03, 16'h1234, 1'b1, 1'b0);
    `BAT_CHK(vend, 16'ha55a)
    wr(8'h02, 16'h0007, 1'b0, 1'b1);
    rd(8'h02, 16'h000a);
    wr(8'h02, 16'h0000, 1'b1, 1'b1);
    `BAT_CHK(ltime, 16'h0000)
    wr(8'h01, 16'h0100, 1'b1, 1'b1);
    meas(1'b0, 16'h0100, 2'b00, 1'b0);
    meas(1'b0, 16'h00ff, 2'b10, 1'b1);
    meas(1'b1, 16'h0000, 2'b10, 1'b1);
    wr(8'h02, 16'h0005, 1'b1, 1'b1);
    meas(1'b1, 16'h0004, 2'b11, 1'b1);
    meas(1'b1, 16'h0005, 2'b10, 1'b1);
    wr(8'h01, 16'h0000, 1'b1, 1'b1);
    `BAT_CHK(cap_al, 1'b0)
    meas(1'b0, 16'h0000, 2'b00, 1'b0);
    cfg = 16'h8000;
    repeat (2) @(negedge i_mclk);
    `BAT_CHK(unit, 1'b1)
    cfg = 16'h0000;
    wr(8'h01, 16'h0100, 1'b1, 1'b1);
    cfg = 16'h2000;
    repeat (4) @(negedge i_mclk);
    meas(1'b0, 16'h0010, 2'b10, 1'b0);
    repeat (SUPP_MS * 50000) @(negedge i_mclk);
    meas(1'b0, 16'h0010, 2'b10, 1'b1);
    cfg = 16'h0000;
    conclude;
  end
endmodule // battery_alarm_threshold_cmds_tb
